// ==== logic/dag_half.sv ====
`timescale 1ns/10ps

// Address arithmetic for one memory space: four triplets and three adders.
module dag_half (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire dag_pkg::dag_req_t req,
    input wire dag_pkg::dag_wr_t wr,
    output logic [23:0] addr,
    output logic [23:0] ptr_new,
    output dag_pkg::dag_mode_t mode
);

    // ----------------------------------------
    // Register triplets
    // ----------------------------------------
    logic [23:0] pointer_reg_q [dag_pkg::NUM_TRIP];
    logic [23:0] pointer_reg_d [dag_pkg::NUM_TRIP];
    logic [23:0] offset_reg_q [dag_pkg::NUM_TRIP];
    logic [23:0] offset_reg_d [dag_pkg::NUM_TRIP];
    logic [23:0] modifier_reg_q [dag_pkg::NUM_TRIP];
    logic [23:0] modifier_reg_d [dag_pkg::NUM_TRIP];
    logic [23:0] addr_q;
    logic [23:0] addr_d;

    logic [23:0] ptr;
    logic [23:0] ofs;
    logic [23:0] mod;
    logic [23:0] sum_ofs;
    logic [23:0] sum_mod;
    logic [23:0] sum_rev;
    logic [23:0] modulus;
    logic [23:0] base;
    logic [23:0] blk_mask;
    logic [23:0] ptr_rev;
    logic [23:0] ofs_rev;
    logic [23:0] rev_tmp;

    // Selected triplet.
    assign ptr = pointer_reg_q[req.sel];
    assign ofs = req.use_offset ? offset_reg_q[req.sel] : req.imm;
    assign mod = modifier_reg_q[req.sel];

    // ----------------------------------------
    // Modifier decode
    // ----------------------------------------
    // modifier picks mode
    always_comb
    begin
        if (mod == dag_pkg::MOD_LINEAR)
            mode = dag_pkg::DAG_LINEAR;
        else if (mod == dag_pkg::MOD_REVERSE)
            mode = dag_pkg::DAG_REVERSE;
        else if (mod <= dag_pkg::MOD_MODULO_MAX)
            mode = dag_pkg::DAG_MODULO;
        else if ((mod & dag_pkg::MOD_MULTI_MASK) == dag_pkg::MOD_MULTI_TAG)
            mode = dag_pkg::DAG_MULTI_WRAP;
        else
            mode = dag_pkg::DAG_LINEAR;
    end

    // ----------------------------------------
    // Adders
    // ----------------------------------------
    // offset adder
    assign sum_ofs = ptr + ofs;

    assign modulus = mod + dag_pkg::ADDR_ONE;

    // Block boundary mask covering the smallest power of two holding the modulus.
    always_comb
    begin
        blk_mask = mod;
        for (int i = 1; i < dag_pkg::ADDR_W; i = i * 2)
        begin
            blk_mask = blk_mask | (blk_mask >> i);
        end
    end
    assign base = ptr & ~blk_mask;

    always_comb
    begin
        if (sum_ofs >= base + modulus)
            sum_mod = sum_ofs - modulus;
        else if (sum_ofs < base)
            sum_mod = sum_ofs + modulus;
        else
            sum_mod = sum_ofs;
    end

    always_comb
    begin
        for (int b = 0; b < dag_pkg::ADDR_W; b++)
        begin
            ptr_rev[b] = ptr[dag_pkg::ADDR_W - 1 - b];
            ofs_rev[b] = ofs[dag_pkg::ADDR_W - 1 - b];
        end
        rev_tmp = ptr_rev + ofs_rev;
        for (int b = 0; b < dag_pkg::ADDR_W; b++)
        begin
            sum_rev[b] = rev_tmp[dag_pkg::ADDR_W - 1 - b];
        end
    end

    // ----------------------------------------
    // Result select and register update
    // ----------------------------------------
    // select adder result
    always_comb
    begin
        unique case (mode)
            dag_pkg::DAG_LINEAR: ptr_new = sum_ofs;
            dag_pkg::DAG_MODULO: ptr_new = sum_mod;
            dag_pkg::DAG_MULTI_WRAP: ptr_new = (sum_ofs & blk_mask) | base;
            dag_pkg::DAG_REVERSE: ptr_new = sum_rev;
        endcase
    end

    // Next values for the triplets; an update writes one pointer per cycle.
    // one update per cycle
    always_comb
    begin
        for (int t = 0; t < dag_pkg::NUM_TRIP; t++)
        begin
            pointer_reg_d[t] = pointer_reg_q[t];
            offset_reg_d[t] = offset_reg_q[t];
            modifier_reg_d[t] = modifier_reg_q[t];
        end
        if (wr.wr)
        begin
            unique case (wr.kind)
                dag_pkg::KIND_PTR: pointer_reg_d[wr.sel] = wr.data;
                dag_pkg::KIND_OFS: offset_reg_d[wr.sel] = wr.data;
                default: modifier_reg_d[wr.sel] = wr.data;
            endcase
        end
        if (req.upd && !(wr.wr && wr.kind == dag_pkg::KIND_PTR && wr.sel == req.sel))
            pointer_reg_d[req.sel] = ptr_new;
        addr_d = req.upd ? ptr : addr_q;
    end

    // Registers the triplets and the outgoing address.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int t = 0; t < dag_pkg::NUM_TRIP; t++)
            begin
                pointer_reg_q[t] <= dag_pkg::ADDR_ZERO;
                offset_reg_q[t] <= dag_pkg::ADDR_ZERO;
                modifier_reg_q[t] <= dag_pkg::MOD_LINEAR;
            end
            addr_q <= dag_pkg::ADDR_ZERO;
        end
        else
        begin
            for (int t = 0; t < dag_pkg::NUM_TRIP; t++)
            begin
                pointer_reg_q[t] <= pointer_reg_d[t];
                offset_reg_q[t] <= offset_reg_d[t];
                modifier_reg_q[t] <= modifier_reg_d[t];
            end
            addr_q <= addr_d;
        end
    end

    assign addr = addr_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // pointer written back
    upd_writeback_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.upd && !wr.wr) |=> pointer_reg_q[$past(req.sel)] == $past(ptr_new))
        else $error("pointer not updated");

    linear_sum_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode == dag_pkg::DAG_LINEAR) |-> ptr_new == ptr + ofs)
        else $error("linear result wrong");

    modulo_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode == dag_pkg::DAG_MODULO && ptr >= base && ptr < base + modulus
         && (ofs < modulus || -ofs <= modulus))
        |-> (ptr_new >= base && ptr_new < base + modulus))
        else $error("modulo result outside buffer");

    // reverse of one adds top bit
    reverse_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode == dag_pkg::DAG_REVERSE && ofs == 24'h800000 && !ptr[23])
        |-> ptr_new == (ptr | 24'h800000))
        else $error("reverse carry wrong");

endmodule

// ==== logic/dag_pkg.sv ====
package dag_pkg;

    // ----------------------------------------
    // Widths and sizes
    // ----------------------------------------
    localparam int ADDR_W = 24;
    localparam int NUM_TRIP = 4;
    localparam int SEL_W = 2;

    // ----------------------------------------
    // Modifier decode codes
    // ----------------------------------------
    // Linear code: every bit set.
    localparam logic [23:0] MOD_LINEAR = 24'hffffff;
    // Reverse-carry code: all zeros.
    localparam logic [23:0] MOD_REVERSE = 24'h000000;
    // Codes from 1 up to this value are single-buffer modulo (modulus = M + 1).
    localparam logic [23:0] MOD_MODULO_MAX = 24'h007fff;
    // Codes whose bits 15 and 14 match this pattern are multiple wrap-around modulo.
    localparam logic [23:0] MOD_MULTI_MASK = 24'h00c000;
    localparam logic [23:0] MOD_MULTI_TAG = 24'h008000;
    localparam logic [23:0] ADDR_ZERO = 24'h000000;
    localparam logic [23:0] ADDR_ONE = 24'h000001;

    // Arithmetic kinds applied to a pointer update.
    typedef enum logic [1:0] {
        DAG_LINEAR,
        DAG_MODULO,
        DAG_MULTI_WRAP,
        DAG_REVERSE
    } dag_mode_t;

    // Update request to one half.
    typedef struct packed {
        logic upd;
        logic [1:0] sel;
        logic use_offset;
        logic signed [23:0] imm;
    } dag_req_t;

    // Register write request to one half.
    typedef struct packed {
        logic wr;
        logic [1:0] kind;
        logic [1:0] sel;
        logic [23:0] data;
    } dag_wr_t;

    // Register kind codes for writes.
    localparam logic [1:0] KIND_PTR = 2'h0;
    localparam logic [1:0] KIND_OFS = 2'h1;
    localparam logic [1:0] KIND_MOD = 2'h2;

endpackage

// ==== logic/dag_top.sv ====
`timescale 1ns/10ps

// Functional notes
// - Pointer updates use linear, modulo, multiple wrap-around or reverse-carry arithmetic.
// - The modifier paired with a pointer selects which arithmetic an update uses.
// - In modulo mode the same modifier value also gives the modulus.
// - Each pointer has its own modifier and every indirect mode works with any modifier.
// - Two halves with separate arithmetic produce 24-bit X and Y addresses each cycle.
// - Each half can update one of its pointers in a single cycle.
// - Each half holds four triplets of pointer, offset and modifier.
// - A 24-bit offset adder adds the offset to the pointer.
// - A modulo adder combines the offset sum with the modulo value for wrapping.
// - A reverse-carry adder runs beside the offset adder with carries flowing downward.
// - The decoded modifier picks which adder result is written back and output.
// - Address work runs alongside the rest of the core and adds no cycles.
module dag_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire dag_pkg::dag_req_t x_req,
    input wire dag_pkg::dag_wr_t x_wr,
    input wire dag_pkg::dag_req_t y_req,
    input wire dag_pkg::dag_wr_t y_wr,
    output logic [23:0] x_addr,
    output logic [23:0] y_addr,
    output logic [23:0] x_ptr_new,
    output logic [23:0] y_ptr_new,
    output dag_pkg::dag_mode_t x_mode,
    output dag_pkg::dag_mode_t y_mode
);

    // ----------------------------------------
    // Two independent halves
    // ----------------------------------------
    // separate X and Y halves
    dag_half u_x (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .req(x_req),
        .wr(x_wr),
        .addr(x_addr),
        .ptr_new(x_ptr_new),
        .mode(x_mode)
    );

    // Y-space half shares nothing with the X-space half.
    dag_half u_y (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .req(y_req),
        .wr(y_wr),
        .addr(y_addr),
        .ptr_new(y_ptr_new),
        .mode(y_mode)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // address follows request
    x_addr_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        x_req.upd |=> x_addr == $past(u_x.ptr))
        else $error("x address not issued");

    y_addr_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        y_req.upd |=> y_addr == $past(u_y.ptr))
        else $error("y address not issued");

    x_addr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !x_req.upd |=> $stable(x_addr))
        else $error("x address moved while idle");

    lin_decode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (u_x.mod == dag_pkg::MOD_LINEAR) |-> x_mode == dag_pkg::DAG_LINEAR)
        else $error("linear decode wrong");

endmodule

// ==== tb/dag_dec_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------
// Decoder and bus stand-in
// ----------------------------------------
// Issues requests to both halves; each request is launched at a falling edge and held
// through the following rising edge, where the block takes it.
module dag_dec_model (
    core_clk,
    x_req,
    x_wr,
    y_req,
    y_wr
);
    input wire logic core_clk;
    output dag_pkg::dag_req_t x_req;
    output dag_pkg::dag_wr_t x_wr;
    output dag_pkg::dag_req_t y_req;
    output dag_pkg::dag_wr_t y_wr;

    // Idle requests from time zero so nothing is taken during reset.
    initial
    begin
        x_req = '0;
        x_wr = '0;
        y_req = '0;
        y_wr = '0;
    end

    // Drives one cycle of requests to both halves.
    task automatic issue(input dag_pkg::dag_req_t xr, input dag_pkg::dag_wr_t xw,
                         input dag_pkg::dag_req_t yr, input dag_pkg::dag_wr_t yw);
        @(negedge core_clk);
        x_req = xr;
        x_wr = xw;
        y_req = yr;
        y_wr = yw;
    endtask
endmodule

// ==== tb/dual_address_generation_unit_tb.sv ====
`timescale 1ns/10ps

module dual_address_generation_unit_tb;
    logic core_clk;
    logic rst_n;
    dag_pkg::dag_req_t x_req;
    dag_pkg::dag_wr_t x_wr;
    dag_pkg::dag_req_t y_req;
    dag_pkg::dag_wr_t y_wr;
    logic [23:0] x_addr;
    logic [23:0] y_addr;
    logic [23:0] x_ptr_new;
    logic [23:0] y_ptr_new;
    dag_pkg::dag_mode_t x_mode;
    dag_pkg::dag_mode_t y_mode;
    int n_fail = 0;
    int comparisons = 0;

    dag_top DUT (.core_clk(core_clk), .rst_n(rst_n), .x_req(x_req), .x_wr(x_wr),
        .y_req(y_req), .y_wr(y_wr), .x_addr(x_addr), .y_addr(y_addr),
        .x_ptr_new(x_ptr_new), .y_ptr_new(y_ptr_new), .x_mode(x_mode), .y_mode(y_mode));
    dag_dec_model DEC (.core_clk(core_clk), .x_req(x_req), .x_wr(x_wr), .y_req(y_req),
        .y_wr(y_wr));

    // Free-running core clock.
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Compares one value and counts the outcome.
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask

    function automatic dag_pkg::dag_req_t rq(input logic [1:0] s, input logic u,
                                             input logic [23:0] im);
        rq = {1'b1, s, u, im};
    endfunction

    function automatic dag_pkg::dag_wr_t wv(input logic [1:0] k, input logic [1:0] s,
                                            input logic [23:0] d);
        wv = {1'b1, k, s, d};
    endfunction

    task automatic t_linear();
        logic [23:0] xp;
        logic [23:0] yp;
        for (int s = 0; s < 4; s++)
        begin
            DEC.issue('0, wv(dag_pkg::KIND_PTR, 2'(s), 24'(256 * (s + 1))), '0,
                      wv(dag_pkg::KIND_PTR, 2'(s), 24'(512 * (s + 1))));
            DEC.issue('0, wv(dag_pkg::KIND_OFS, 2'(s), 24'(s + 1)), '0,
                      wv(dag_pkg::KIND_OFS, 2'(s), 24'h000010));
        end
        for (int s = 0; s < 4; s++)
        begin
            xp = 24'(256 * (s + 1));
            yp = 24'(512 * (s + 1));
            DEC.issue(rq(2'(s), 1'b1, '0), '0, rq(2'(s), 1'b1, '0), '0);
            #1;
            chk("x_ptr_new", xp + 24'(s + 1), x_ptr_new);
            chk("y_ptr_new", yp + 24'h000010, y_ptr_new);
            DEC.issue('0, '0, '0, '0);
            chk("x_addr", xp, x_addr);
            chk("y_addr", yp, y_addr);
        end
        DEC.issue(rq(2'h0, 1'b0, 24'hfffffe), '0, '0, '0);
        DEC.issue(rq(2'h0, 1'b0, 24'hfffffe), '0, '0, '0);
        #1;
        chk("x_ptr_new", 24'h0000fd, x_ptr_new);
        chk("x_addr", 24'h000101, x_addr);
        DEC.issue('0, '0, '0, '0);
        chk("x_addr", 24'h0000ff, x_addr);
    endtask

    task automatic t_modulo();
        logic [23:0] e [5] = '{24'h000023, 24'h000026, 24'h000029, 24'h000022, 24'h000025};
        DEC.issue('0, wv(dag_pkg::KIND_MOD, 2'h1, 24'h000009), '0, '0);
        DEC.issue('0, wv(dag_pkg::KIND_PTR, 2'h1, 24'h000020), '0, '0);
        for (int i = 0; i < 5; i++)
        begin
            DEC.issue(rq(2'h1, 1'b0, (i < 4) ? 24'h000003 : 24'hfffff9), '0, '0, '0);
            #1;
            chk("x_ptr_new", e[i], x_ptr_new);
            chk("x_mode", 24'(dag_pkg::DAG_MODULO), 24'(x_mode));
        end
    endtask

    task automatic t_reverse();
        logic [23:0] e [4] = '{24'h800000, 24'h400000, 24'hc00000, 24'h200000};
        DEC.issue('0, '0, '0, wv(dag_pkg::KIND_MOD, 2'h3, 24'h000000));
        DEC.issue('0, '0, '0, wv(dag_pkg::KIND_PTR, 2'h3, 24'h000000));
        DEC.issue('0, '0, '0, wv(dag_pkg::KIND_OFS, 2'h3, 24'h800000));
        for (int i = 0; i < 4; i++)
        begin
            DEC.issue('0, '0, rq(2'h3, 1'b1, '0), '0);
            #1;
            chk("y_ptr_new", e[i], y_ptr_new);
        end
    endtask

    task automatic t_modes();
        logic [23:0] c [5] = '{24'hffffff, 24'h000005, 24'h008003, 24'h000000, 24'h00c000};
        logic [23:0] m [5] = '{24'h0, 24'h1, 24'h2, 24'h3, 24'h0};
        for (int i = 0; i < 5; i++)
        begin
            DEC.issue('0, wv(dag_pkg::KIND_MOD, 2'h2, c[i]), '0, '0);
            DEC.issue({1'b0, 2'h2, 1'b0, 24'h000000}, '0, '0, '0);
            #1;
            chk("x_mode", m[i], 24'(x_mode));
        end
    endtask

    task automatic t_collide();
        DEC.issue(rq(2'h0, 1'b0, 24'h000001), wv(dag_pkg::KIND_PTR, 2'h0, 24'h000555), '0, '0);
        DEC.issue(rq(2'h0, 1'b0, 24'h000000), '0, '0, '0);
        #1;
        chk("x_ptr_new", 24'h000555, x_ptr_new);
        chk("x_addr", 24'h0000fd, x_addr);
    endtask

    task automatic t_multi();
        DEC.issue('0, '0, '0, wv(dag_pkg::KIND_MOD, 2'h1, 24'h008003));
        DEC.issue('0, '0, '0, wv(dag_pkg::KIND_PTR, 2'h1, 24'h00fffe));
        DEC.issue('0, '0, rq(2'h1, 1'b0, 24'h000003), '0);
        #1;
        chk("y_mode", 24'(dag_pkg::DAG_MULTI_WRAP), 24'(y_mode));
        chk("y_ptr_new", 24'h000001, y_ptr_new);
        DEC.issue('0, '0, '0, '0);
        chk("y_addr", 24'h00fffe, y_addr);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Cuts a hang short well past the expected run length.
    initial
    begin
        repeat (3000) @(posedge core_clk);
        n_fail++;
        end_of_test();
    end

    // Main sequence.
    initial
    begin
        rst_n = 1'b0;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        chk("x_addr", 24'h000000, x_addr);
        chk("x_mode", 24'(dag_pkg::DAG_LINEAR), 24'(x_mode));
        t_linear();
        t_modulo();
        t_reverse();
        t_modes();
        t_collide();
        t_multi();
        end_of_test();
    end
endmodule
